// ===== shared/temp_pkg.sv
// Summary of operation
// - After supply is good, spend an initialization interval before serving the bus.
// - Ignore the bus while initializing, then wait for a host bus reset.
// - Reload short address, alert thresholds and offset from nonvolatile copies.
// - Reload the IO configuration register from its nonvolatile copy.
// - Restore both device configuration registers from nonvolatile memory.
// - Arbitration select of 10b or 11b makes address search use arbitration.
// - Fast speed enable starts overdrive unless first bus reset is standard speed.
// - Restore user memory protection bits from nonvolatile memory.
// - On loss of supply, keep all settings while the capacitor holds up.
// - Brown-out shuts the device off; next power-up is bus powered, full reload.
// - Convert on command unless automatic, after presence detect if automatic, or continuously on supply power.
// - Each finished conversion updates the result registers and status.
// - Format select bit chooses precision or legacy encoding; legacy by default.
// - Precision format is 16-bit two's complement at 7.8125 mdegC per LSB.
// - Legacy format is 12-bit at 62.5 mdegC, sign copied into top five bits.
// - Result reads as zero degrees before the first conversion.
// - Legacy result saturates at 07FF at or above the largest positive value.
package temp_pkg;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_MHZ = 100;
	localparam int TICK_NS = 1000;
	localparam int TICK_CYCLES = (TICK_NS * CLK_MHZ) / 1000;
	localparam int INIT_TIME_US = 1000;
	localparam int INIT_CNT_W = 20;

	// ----------------------------------------
	// Nonvolatile copy layout
	// ----------------------------------------
	localparam int NV_WIDTH = 16;
	localparam int NV_DEPTH = 8;
	localparam int NV_AW = 3;
	localparam logic [2:0] NV_SHORT = 3'h0;
	localparam logic [2:0] NV_ALERT_LOW = 3'h1;
	localparam logic [2:0] NV_ALERT_HIGH = 3'h2;
	localparam logic [2:0] NV_OFFSET = 3'h3;
	localparam logic [2:0] NV_IO_CFG = 3'h4;
	localparam logic [2:0] NV_CFG1 = 3'h5;
	localparam logic [2:0] NV_CFG2 = 3'h6;
	localparam logic [2:0] NV_PROTECT = 3'h7;

	// ----------------------------------------
	// Configuration-1 fields
	// ----------------------------------------
	localparam int CFG1_FMT_BIT = 0;
	localparam int CFG1_AUTO_BIT = 1;
	localparam int CFG1_CONT_BIT = 2;
	localparam int CFG1_ARB_HI_BIT = 4;
	localparam int CFG1_FAST_BIT = 5;
	localparam logic [7:0] CFG1_RESET = 8'h00;
	localparam logic FMT_LEGACY = 1'b0;

	// ----------------------------------------
	// Result encoding
	// ----------------------------------------
	localparam logic [15:0] RESULT_ZERO = 16'h0000;
	localparam logic [15:0] LEGACY_MAX = 16'h07FF;
	localparam logic [15:0] LEGACY_MIN = 16'hF800;
	localparam logic [15:0] HP_POS_LIMIT = 16'h4000;
	localparam logic [15:0] HP_NEG_LIMIT = 16'hC000;
	localparam int LEGACY_SHIFT = 3;

	typedef enum logic [2:0] {
		ST_OFF = 3'b000,
		ST_LOAD = 3'b001,
		ST_WAIT_INIT = 3'b010,
		ST_WAIT_RESET = 3'b011,
		ST_ACTIVE = 3'b100,
		ST_DOWN = 3'b101
	} state_t;

	typedef struct packed {
		logic [7:0] short_addr;
		logic [15:0] alert_low;
		logic [15:0] alert_high;
		logic [15:0] offset;
		logic [7:0] io_cfg;
		logic [7:0] cfg1;
		logic [7:0] cfg2;
		logic [7:0] protect;
	} settings_t;
endpackage

// ===== rtl/nv_store.sv
`timescale 1ns/100ps
`default_nettype none
module nv_store #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8,
	parameter int AW = 3
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic wr_en_i,
	input wire logic [AW-1:0] wr_addr_i,
	input wire logic [WIDTH-1:0] wr_data_i,
	input wire logic rd_en_i,
	input wire logic [AW-1:0] rd_addr_i,
	output logic [WIDTH-1:0] rd_data_o
);
	// Array has no reset: it stands for storage that outlives power
	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge clk_i) begin
		if (wr_en_i) begin
			mem[wr_addr_i] <= wr_data_i;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rd_data_o <= '0;
		end else if (rd_en_i) begin
			rd_data_o <= mem[rd_addr_i];
		end
	end
endmodule
`default_nettype wire

// ===== rtl/result_format.sv
`timescale 1ns/100ps
`default_nettype none
module result_format (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic clear_i,
	input wire logic load_i,
	input wire logic fmt_i,
	input wire logic [15:0] raw_i,
	output logic [15:0] result_o
);
	logic [15:0] nxt_legacy;

	// ----------------------------------------
	// Legacy encoding
	// ----------------------------------------
	always_comb begin
		if ($signed(raw_i) >= $signed(temp_pkg::HP_POS_LIMIT)) begin
			nxt_legacy = temp_pkg::LEGACY_MAX;
		end else if ($signed(raw_i) < $signed(temp_pkg::HP_NEG_LIMIT)) begin
			nxt_legacy = temp_pkg::LEGACY_MIN;
		end else begin
			nxt_legacy = 16'($signed(raw_i) >>> temp_pkg::LEGACY_SHIFT);
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			result_o <= temp_pkg::RESULT_ZERO;
		end else if (clear_i) begin
			result_o <= temp_pkg::RESULT_ZERO;
		end else if (load_i) begin
			result_o <= (fmt_i == temp_pkg::FMT_LEGACY) ? nxt_legacy : raw_i;
		end
	end

	a_legacy_saturate: assert property (@(posedge clk_i) disable iff (!rstn_i)
		load_i && !clear_i && fmt_i == temp_pkg::FMT_LEGACY
		&& $signed(raw_i) >= $signed(temp_pkg::HP_POS_LIMIT)
		|=> result_o == temp_pkg::LEGACY_MAX)
		else $error("legacy result not saturated");
endmodule
`default_nettype wire

// ===== rtl/temp_init_core.sv
`timescale 1ns/100ps
`default_nettype none
module temp_init_core #(
	parameter int INIT_TIME_US = temp_pkg::INIT_TIME_US
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic supply_good_i,
	input wire logic vdd_powered_i,
	input wire logic cap_brownout_i,
	input wire logic bus_reset_i,
	input wire logic bus_reset_std_speed_i,
	input wire logic presence_done_i,
	input wire logic convert_cmd_i,
	input wire logic adc_done_i,
	input wire logic [15:0] adc_data_i,
	input wire logic nv_wr_en_i,
	input wire logic [temp_pkg::NV_AW-1:0] nv_wr_addr_i,
	input wire logic [temp_pkg::NV_WIDTH-1:0] nv_wr_data_i,
	output logic bus_enable_o,
	output logic overdrive_o,
	output logic arbitration_search_o,
	output logic bus_powered_o,
	output logic conv_start_o,
	output logic conv_busy_o,
	output logic result_ready_o,
	output logic [7:0] temperature_result_high_o,
	output logic [7:0] temperature_result_low_o,
	output var temp_pkg::settings_t settings_o
);
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	localparam int INIT_CNT_W_L = temp_pkg::INIT_CNT_W;
	localparam logic [INIT_CNT_W_L-1:0] INIT_TICKS = INIT_CNT_W_L'(INIT_TIME_US);
	localparam logic [7:0] TICK_LAST = 8'(temp_pkg::TICK_CYCLES - 1);

	temp_pkg::state_t state_ff;
	temp_pkg::settings_t settings_ff;
	logic [7:0] tick_cnt_ff;
	logic tick_ff;
	logic [INIT_CNT_W_L-1:0] init_cnt_ff;
	logic init_done;
	logic [temp_pkg::NV_AW-1:0] load_idx_ff;
	logic [temp_pkg::NV_AW-1:0] cap_idx_ff;
	logic load_rd_ff;
	logic cap_valid_ff;
	logic load_done_ff;
	logic [temp_pkg::NV_WIDTH-1:0] nv_rd_data;
	logic bus_enable_ff;
	logic overdrive_ff;
	logic arb_search_ff;
	logic bus_powered_ff;
	logic conv_start_ff;
	logic conv_busy_ff;
	logic result_ready_ff;
	logic start_req;
	logic result_clear;
	logic [15:0] result;

	// ----------------------------------------
	// Microsecond tick divider
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tick_cnt_ff <= 8'h00;
			tick_ff <= 1'b0;
		end else if (tick_cnt_ff == TICK_LAST) begin
			tick_cnt_ff <= 8'h00;
			tick_ff <= 1'b1;
		end else begin
			tick_cnt_ff <= tick_cnt_ff + 8'h01;
			tick_ff <= 1'b0;
		end
	end

	// ----------------------------------------
	// Initialization interval
	// ----------------------------------------
	assign init_done = init_cnt_ff >= INIT_TICKS;

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			init_cnt_ff <= '0;
		end else if (state_ff != temp_pkg::ST_LOAD && state_ff != temp_pkg::ST_WAIT_INIT) begin
			init_cnt_ff <= '0;
		end else if (tick_ff && !init_done) begin
			init_cnt_ff <= init_cnt_ff + 1'b1;
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_ff <= temp_pkg::ST_OFF;
		end else if (cap_brownout_i && state_ff != temp_pkg::ST_OFF) begin
			state_ff <= temp_pkg::ST_DOWN;
		end else begin
			case (state_ff)
				temp_pkg::ST_OFF: begin
					if (supply_good_i) begin
						state_ff <= temp_pkg::ST_LOAD;
					end
				end
				temp_pkg::ST_LOAD: begin
					if (load_done_ff) begin
						state_ff <= temp_pkg::ST_WAIT_INIT;
					end
				end
				temp_pkg::ST_WAIT_INIT: begin
					if (init_done) begin
						state_ff <= temp_pkg::ST_WAIT_RESET;
					end
				end
				temp_pkg::ST_WAIT_RESET: begin
					if (bus_reset_i) begin
						state_ff <= temp_pkg::ST_ACTIVE;
					end
				end
				temp_pkg::ST_ACTIVE: begin
					state_ff <= temp_pkg::ST_ACTIVE;
				end
				temp_pkg::ST_DOWN: begin
					if (supply_good_i) begin
						state_ff <= temp_pkg::ST_LOAD;
					end
				end
				default: begin
					state_ff <= temp_pkg::ST_OFF;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Nonvolatile reload walk
	// ----------------------------------------
	nv_store #(
		.WIDTH(temp_pkg::NV_WIDTH),
		.DEPTH(temp_pkg::NV_DEPTH),
		.AW(temp_pkg::NV_AW)
	) u_nv (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.wr_en_i(nv_wr_en_i),
		.wr_addr_i(nv_wr_addr_i),
		.wr_data_i(nv_wr_data_i),
		.rd_en_i(load_rd_ff),
		.rd_addr_i(load_idx_ff),
		.rd_data_o(nv_rd_data)
	);

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			load_idx_ff <= '0;
			load_rd_ff <= 1'b0;
			cap_idx_ff <= '0;
			cap_valid_ff <= 1'b0;
			load_done_ff <= 1'b0;
		end else if (state_ff != temp_pkg::ST_LOAD || cap_brownout_i) begin
			load_idx_ff <= '0;
			load_rd_ff <= (state_ff == temp_pkg::ST_OFF || state_ff == temp_pkg::ST_DOWN)
				&& supply_good_i && !cap_brownout_i;
			cap_valid_ff <= 1'b0;
			load_done_ff <= 1'b0;
		end else begin
			cap_idx_ff <= load_idx_ff;
			cap_valid_ff <= load_rd_ff;
			if (load_rd_ff) begin
				load_idx_ff <= load_idx_ff + 1'b1;
				load_rd_ff <= load_idx_ff != temp_pkg::NV_PROTECT;
			end
			load_done_ff <= cap_valid_ff && cap_idx_ff == temp_pkg::NV_PROTECT;
		end
	end

	// Settings stay as they are across a supply loss; only a reload replaces them
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			settings_ff <= '0;
			settings_ff.cfg1 <= temp_pkg::CFG1_RESET;
		end else if (cap_valid_ff && state_ff == temp_pkg::ST_LOAD) begin
			case (cap_idx_ff)
				temp_pkg::NV_SHORT: settings_ff.short_addr <= nv_rd_data[7:0];
				temp_pkg::NV_ALERT_LOW: settings_ff.alert_low <= nv_rd_data;
				temp_pkg::NV_ALERT_HIGH: settings_ff.alert_high <= nv_rd_data;
				temp_pkg::NV_OFFSET: settings_ff.offset <= nv_rd_data;
				temp_pkg::NV_IO_CFG: settings_ff.io_cfg <= nv_rd_data[7:0];
				temp_pkg::NV_CFG1: settings_ff.cfg1 <= nv_rd_data[7:0];
				temp_pkg::NV_CFG2: settings_ff.cfg2 <= nv_rd_data[7:0];
				temp_pkg::NV_PROTECT: settings_ff.protect <= nv_rd_data[7:0];
				default: settings_ff.protect <= settings_ff.protect;
			endcase
		end
	end

	// ----------------------------------------
	// Bus side modes
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			bus_enable_ff <= 1'b0;
			overdrive_ff <= 1'b0;
			arb_search_ff <= 1'b0;
		end else if (state_ff == temp_pkg::ST_WAIT_RESET && bus_reset_i && !cap_brownout_i) begin
			bus_enable_ff <= 1'b1;
			overdrive_ff <= settings_ff.cfg1[temp_pkg::CFG1_FAST_BIT]
				&& !bus_reset_std_speed_i;
			arb_search_ff <= settings_ff.cfg1[temp_pkg::CFG1_ARB_HI_BIT];
		end else if (state_ff != temp_pkg::ST_ACTIVE || cap_brownout_i) begin
			bus_enable_ff <= 1'b0;
			overdrive_ff <= 1'b0;
			arb_search_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			bus_powered_ff <= 1'b0;
		end else if (state_ff == temp_pkg::ST_DOWN || !vdd_powered_i) begin
			bus_powered_ff <= 1'b1;
		end
	end

	// ----------------------------------------
	// Conversion control
	// ----------------------------------------
	// Continuous mode only runs on supply power: the line cannot feed it
	assign start_req = state_ff == temp_pkg::ST_ACTIVE && !cap_brownout_i
		&& !conv_busy_ff && !conv_start_ff
		&& ((convert_cmd_i && !settings_ff.cfg1[temp_pkg::CFG1_AUTO_BIT])
		|| (presence_done_i && settings_ff.cfg1[temp_pkg::CFG1_AUTO_BIT])
		|| (!bus_powered_ff && settings_ff.cfg1[temp_pkg::CFG1_CONT_BIT]));

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			conv_start_ff <= 1'b0;
			conv_busy_ff <= 1'b0;
		end else if (state_ff != temp_pkg::ST_ACTIVE || cap_brownout_i) begin
			conv_start_ff <= 1'b0;
			conv_busy_ff <= 1'b0;
		end else begin
			conv_start_ff <= start_req;
			if (start_req) begin
				conv_busy_ff <= 1'b1;
			end else if (adc_done_i) begin
				conv_busy_ff <= 1'b0;
			end
		end
	end

	assign result_clear = state_ff == temp_pkg::ST_DOWN;

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			result_ready_ff <= 1'b0;
		end else if (result_clear) begin
			result_ready_ff <= 1'b0;
		end else if (conv_busy_ff && adc_done_i && state_ff == temp_pkg::ST_ACTIVE
			&& !cap_brownout_i) begin
			result_ready_ff <= 1'b1;
		end
	end

	result_format u_fmt (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.clear_i(result_clear),
		.load_i(conv_busy_ff && adc_done_i && state_ff == temp_pkg::ST_ACTIVE
			&& !cap_brownout_i),
		.fmt_i(settings_ff.cfg1[temp_pkg::CFG1_FMT_BIT]),
		.raw_i(adc_data_i),
		.result_o(result)
	);

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign bus_enable_o = bus_enable_ff;
	assign overdrive_o = overdrive_ff;
	assign arbitration_search_o = arb_search_ff;
	assign bus_powered_o = bus_powered_ff;
	assign conv_start_o = conv_start_ff;
	assign conv_busy_o = conv_busy_ff;
	assign result_ready_o = result_ready_ff;
	assign temperature_result_high_o = result[15:8];
	assign temperature_result_low_o = result[7:0];
	assign settings_o = settings_ff;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_bus_quiet_init: assert property (@(posedge clk_i) disable iff (!rstn_i)
		state_ff != temp_pkg::ST_ACTIVE |-> !bus_enable_ff)
		else $error("bus served outside active state");

	a_init_before_bus: assert property (@(posedge clk_i) disable iff (!rstn_i)
		state_ff == temp_pkg::ST_WAIT_INIT && !init_done |=> state_ff != temp_pkg::ST_WAIT_RESET)
		else $error("init interval cut short");

	a_reset_opens_bus: assert property (@(posedge clk_i) disable iff (!rstn_i)
		state_ff == temp_pkg::ST_WAIT_RESET && bus_reset_i && !cap_brownout_i
		|=> bus_enable_ff && state_ff == temp_pkg::ST_ACTIVE)
		else $error("bus reset did not open bus");

	a_short_reload: assert property (@(posedge clk_i) disable iff (!rstn_i)
		cap_valid_ff && state_ff == temp_pkg::ST_LOAD && cap_idx_ff == temp_pkg::NV_SHORT
		|=> settings_ff.short_addr == $past(nv_rd_data[7:0]))
		else $error("short address not reloaded");

	a_io_reload: assert property (@(posedge clk_i) disable iff (!rstn_i)
		cap_valid_ff && state_ff == temp_pkg::ST_LOAD && cap_idx_ff == temp_pkg::NV_IO_CFG
		|=> settings_ff.io_cfg == $past(nv_rd_data[7:0]))
		else $error("io configuration not reloaded");

	a_cfg_reload: assert property (@(posedge clk_i) disable iff (!rstn_i)
		cap_valid_ff && state_ff == temp_pkg::ST_LOAD && cap_idx_ff == temp_pkg::NV_CFG1
		|=> settings_ff.cfg1 == $past(nv_rd_data[7:0]))
		else $error("configuration not reloaded");

	a_arb_select: assert property (@(posedge clk_i) disable iff (!rstn_i)
		$rose(bus_enable_ff) |-> arb_search_ff == settings_ff.cfg1[temp_pkg::CFG1_ARB_HI_BIT])
		else $error("arbitration mode mismatch");

	a_speed_pick: assert property (@(posedge clk_i) disable iff (!rstn_i)
		$rose(bus_enable_ff) |-> overdrive_ff
		== (settings_ff.cfg1[temp_pkg::CFG1_FAST_BIT] && !$past(bus_reset_std_speed_i)))
		else $error("wrong starting speed");

	a_brownout_off: assert property (@(posedge clk_i) disable iff (!rstn_i)
		cap_brownout_i && state_ff != temp_pkg::ST_OFF
		|=> state_ff == temp_pkg::ST_DOWN && !bus_enable_ff ##1 bus_powered_ff)
		else $error("brown-out did not shut down");

	a_conv_origin: assert property (@(posedge clk_i) disable iff (!rstn_i)
		conv_start_ff |-> $past(state_ff) == temp_pkg::ST_ACTIVE && conv_busy_ff)
		else $error("conversion started while not active");

	a_result_update: assert property (@(posedge clk_i) disable iff (!rstn_i)
		conv_busy_ff && adc_done_i && state_ff == temp_pkg::ST_ACTIVE && !cap_brownout_i
		|=> result_ready_ff && !conv_busy_ff)
		else $error("conversion end not recorded");

	a_zero_before: assert property (@(posedge clk_i) disable iff (!rstn_i)
		!result_ready_ff |-> result == temp_pkg::RESULT_ZERO)
		else $error("nonzero result before first conversion");
endmodule
`default_nettype wire

// ===== tb/host_model.sv
`timescale 1ns/100ps
`default_nettype none
module host_model #(
	parameter int CONV_CYCLES = 20
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic conv_start_i,
	input wire logic conv_busy_i,
	input wire logic [15:0] adc_value_i,
	output logic bus_reset_o,
	output logic bus_reset_std_speed_o,
	output logic presence_done_o,
	output logic convert_cmd_o,
	output logic adc_done_o,
	output logic [15:0] adc_data_o
);
	// ----------------------------------------
	// Host side requests
	// ----------------------------------------
	int cnt;

	initial begin
		bus_reset_o = 1'b0;
		bus_reset_std_speed_o = 1'b0;
		presence_done_o = 1'b0;
		convert_cmd_o = 1'b0;
	end

	// Line left idle while the sensor converts
	task automatic idle_wait();
		while (conv_busy_i === 1'b1) @(negedge clk_i);
	endtask

	task automatic pulse_reset(input logic std);
		idle_wait();
		bus_reset_o = 1'b1;
		bus_reset_std_speed_o = std;
		@(negedge clk_i);
		bus_reset_o = 1'b0;
		// Speed level means nothing outside the pulse
		bus_reset_std_speed_o = ~std;
	endtask

	task automatic pulse_presence();
		idle_wait();
		presence_done_o = 1'b1;
		@(negedge clk_i);
		presence_done_o = 1'b0;
	endtask

	task automatic pulse_convert();
		idle_wait();
		convert_cmd_o = 1'b1;
		@(negedge clk_i);
		convert_cmd_o = 1'b0;
	endtask

	// ----------------------------------------
	// Converter answer
	// ----------------------------------------
	// Data toggles when not valid so a stale value is never mistaken
	always @(negedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt <= 0;
			adc_done_o <= 1'b0;
			adc_data_o <= 16'h0000;
		end else begin
			adc_done_o <= 1'b0;
			adc_data_o <= ~adc_data_o;
			if (conv_start_i) begin
				cnt <= CONV_CYCLES;
			end else if (cnt != 0) begin
				cnt <= cnt - 1;
				if (cnt == 1) begin
					adc_done_o <= 1'b1;
					adc_data_o <= adc_value_i;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic clk_i, rstn_i, supply_good_i, vdd_powered_i, cap_brownout_i;
	logic bus_reset_i, bus_reset_std_speed_i, presence_done_i, convert_cmd_i;
	logic adc_done_i, nv_wr_en_i;
	logic [15:0] adc_data_i, adc_value, nv_wr_data_i;
	logic [2:0] nv_wr_addr_i;
	logic bus_enable_o, overdrive_o, arbitration_search_o, bus_powered_o;
	logic conv_start_o, conv_busy_o, result_ready_o;
	logic [7:0] temperature_result_high_o, temperature_result_low_o;
	temp_pkg::settings_t settings_o, exp_set;
	int n_errors, samples_checked, cycles, n_starts;
	logic [15:0] raw_tab [5];
	logic [15:0] leg_tab [5];

	temp_init_core #(.INIT_TIME_US(2)) temp_init_core_i (.clk_i(clk_i), .rstn_i(rstn_i),
		.supply_good_i(supply_good_i), .vdd_powered_i(vdd_powered_i),
		.cap_brownout_i(cap_brownout_i), .bus_reset_i(bus_reset_i),
		.bus_reset_std_speed_i(bus_reset_std_speed_i), .presence_done_i(presence_done_i),
		.convert_cmd_i(convert_cmd_i), .adc_done_i(adc_done_i), .adc_data_i(adc_data_i),
		.nv_wr_en_i(nv_wr_en_i), .nv_wr_addr_i(nv_wr_addr_i), .nv_wr_data_i(nv_wr_data_i),
		.bus_enable_o(bus_enable_o), .overdrive_o(overdrive_o),
		.arbitration_search_o(arbitration_search_o), .bus_powered_o(bus_powered_o),
		.conv_start_o(conv_start_o), .conv_busy_o(conv_busy_o),
		.result_ready_o(result_ready_o),
		.temperature_result_high_o(temperature_result_high_o),
		.temperature_result_low_o(temperature_result_low_o), .settings_o(settings_o));

	host_model host_model_i (.clk_i(clk_i), .rstn_i(rstn_i), .conv_start_i(conv_start_o),
		.conv_busy_i(conv_busy_o), .adc_value_i(adc_value), .bus_reset_o(bus_reset_i),
		.bus_reset_std_speed_o(bus_reset_std_speed_i), .presence_done_o(presence_done_i),
		.convert_cmd_o(convert_cmd_i), .adc_done_o(adc_done_i), .adc_data_o(adc_data_i));

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input string what, input logic [95:0] exp, input logic [95:0] got);
		samples_checked++;
		if (got !== exp) begin
			$display("Error %s expected %h seen %h", what, exp, got);
			n_errors++;
		end
	endtask

	task automatic test_done();
		$display("Comparisons %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Preload copies, then bring the supply up and check the reload
	task automatic power_up(input logic [7:0] c1, input logic std, input logic early);
		logic [15:0] img [8];
		exp_set = {8'h5A, 16'hF380, 16'h3200, 16'h0010, 8'h0C, c1, 8'h41, 8'h0F};
		img = '{16'h005A, 16'hF380, 16'h3200, 16'h0010, 16'h000C, {8'h00, c1}, 16'h0041,
			16'h000F};
		for (int i = 0; i < 8; i++) begin
			nv_wr_en_i = 1'b1;
			nv_wr_addr_i = i[2:0];
			nv_wr_data_i = img[i];
			@(negedge clk_i);
		end
		nv_wr_en_i = 1'b0;
		supply_good_i = 1'b1;
		repeat (50) @(negedge clk_i);
		if (early)
			host_model_i.pulse_reset(1'b0);
		chk("bus enable in init", 96'h0, {95'h0, bus_enable_o});
		repeat (300) @(negedge clk_i);
		chk("bus enable before reset", 96'h0, {95'h0, bus_enable_o});
		chk("settings", {8'h00, exp_set}, {8'h00, settings_o});
		host_model_i.pulse_reset(std);
		chk("bus enable", 96'h1, {95'h0, bus_enable_o});
		chk("arbitration", {95'h0, c1[4]}, {95'h0, arbitration_search_o});
		chk("overdrive", {95'h0, c1[5] & ~std}, {95'h0, overdrive_o});
	endtask

	// One conversion, by command or by presence, and the stored result
	task automatic do_conv(input logic by_presence, input logic [15:0] raw,
		input logic [15:0] exp);
		adc_value = raw;
		if (by_presence)
			host_model_i.pulse_presence();
		else
			host_model_i.pulse_convert();
		for (int i = 0; i < 10 && conv_busy_o !== 1'b1; i++) @(negedge clk_i);
		for (int i = 0; i < 100 && conv_busy_o !== 1'b0; i++) @(negedge clk_i);
		chk("result", {80'h0, exp}, {80'h0, temperature_result_high_o,
			temperature_result_low_o});
		chk("result ready", 96'h1, {95'h0, result_ready_o});
	endtask

	// Hang guard: about 1400 cycles expected
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			test_done();
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		rstn_i = 1'b0;
		supply_good_i = 1'b0;
		vdd_powered_i = 1'b1;
		cap_brownout_i = 1'b0;
		nv_wr_en_i = 1'b0;
		nv_wr_addr_i = 3'h0;
		nv_wr_data_i = 16'h0000;
		adc_value = 16'h0000;
		raw_tab = '{16'h0C80, 16'h4B00, 16'h3FF8, 16'hFF80, 16'hFFF0};
		leg_tab = '{16'h0190, 16'h07FF, 16'h07FF, 16'hFFF0, 16'hFFFE};
		repeat (3) @(negedge clk_i);
		rstn_i = 1'b1;
		chk("result at start", 96'h0, {80'h0, temperature_result_high_o,
			temperature_result_low_o});
		power_up(8'h30, 1'b0, 1'b1);
		for (int i = 0; i < 5; i++)
			do_conv(1'b0, raw_tab[i], leg_tab[i]);
		host_model_i.pulse_presence();
		repeat (5) @(negedge clk_i);
		chk("busy after presence", 96'h0, {95'h0, conv_busy_o});
		$display("test legacy done");

		cap_brownout_i = 1'b1;
		supply_good_i = 1'b0;
		repeat (2) @(negedge clk_i);
		cap_brownout_i = 1'b0;
		chk("bus enable off", 96'h0, {95'h0, bus_enable_o});
		chk("result cleared", 96'h0, {79'h0, result_ready_o, temperature_result_high_o,
			temperature_result_low_o});
		power_up(8'h23, 1'b1, 1'b0);
		do_conv(1'b1, 16'hF380, 16'hF380);
		do_conv(1'b1, 16'h4B00, 16'h4B00);
		host_model_i.pulse_convert();
		repeat (5) @(negedge clk_i);
		chk("busy after command", 96'h0, {95'h0, conv_busy_o});
		$display("test precision done");

		rstn_i = 1'b0;
		vdd_powered_i = 1'b1;
		supply_good_i = 1'b0;
		repeat (3) @(negedge clk_i);
		rstn_i = 1'b1;
		adc_value = 16'h0320;
		power_up(8'h04, 1'b1, 1'b0);
		n_starts = 0;
		repeat (100) begin
			@(negedge clk_i);
			if (conv_start_o === 1'b1)
				n_starts++;
		end
		chk("repeated starts", 96'h1, {95'h0, n_starts >= 2});
		chk("continuous result", 96'h0064, {80'h0, temperature_result_high_o,
			temperature_result_low_o});
		chk("supply powered", 96'h0, {95'h0, bus_powered_o});
		$display("test continuous done");

		// Supply drops while converting: settings stay, repeats stop
		vdd_powered_i = 1'b0;
		repeat (2) @(negedge clk_i);
		chk("bus powered", 96'h1, {95'h0, bus_powered_o});
		chk("bus enable kept", 96'h1, {95'h0, bus_enable_o});
		chk("settings kept", {8'h00, exp_set}, {8'h00, settings_o});
		n_starts = 0;
		repeat (60) begin
			@(negedge clk_i);
			if (conv_start_o !== 1'b0)
				n_starts++;
		end
		chk("starts on line power", 96'h0, {64'h0, n_starts});
		$display("test supply loss done");
		test_done();
	end
endmodule
`default_nettype wire
